/* File: verilog/pmc_pkg.sv */
// Summary of operation
// RULE1: Nine operating modes, eight of them power-down
// RULE2: Only high-speed active is not power-down
// RULE3: High-speed active: everything on full system clock
// RULE4: Medium-speed active: everything on reduced system clock
// RULE5: Subactive: CPU and peripherals on subclock
// RULE6: High-speed sleep: CPU halts, peripherals on clock
// RULE7: Medium-speed sleep: peripherals at 1/128..1/16 clock
// RULE8: Subsleep: timers A,C,F,G, serial, counter, display run
// RULE9: Watch: timers A,F,G, counter, display run
// RULE10: Standby halts CPU and every peripheral
// RULE11: Software halts chosen peripherals individually
// RULE12: Only enabled interrupts cause mode changes
// RULE13: Wake set one: timers A,F,G, line 0, pins
// RULE14: Broad wake set: timers, serial, lines 4,3,1,0, counter, pins
// RULE15: Narrow set: lines 1 or 0, pins; another all
// RULE16: Sleep target from five control bits
// RULE17: System oscillator stops in watch, sub, standby
// RULE18: Standby bit picks sleep or standby/watch
// RULE19: Exit wait from 3-bit select, default 8192
// RULE20: At least eight states wait after clock restart; the code gives only 2 for select code 5
package pmc_pkg;

  // Operating modes
  typedef enum logic [3:0] {
    PMC_ACT_HI, PMC_ACT_MED, PMC_SUBACT, PMC_SLP_HI, PMC_SLP_MED,
    PMC_SUBSLP, PMC_WATCH, PMC_STANDBY, PMC_WAIT
  } pmc_mode_t;

  // Peripheral index positions in the clock-enable vector
  localparam int PMC_NPER = 10;
  localparam int PER_TMA = 0;
  localparam int PER_TMC = 1;
  localparam int PER_TMF = 2;
  localparam int PER_TMG = 3;
  localparam int PER_SER = 4;
  localparam int PER_AEC = 5;
  localparam int PER_LCD = 6;
  localparam int PER_WDT = 7;
  localparam int PER_PWM = 8;
  localparam int PER_ADC = 9;

  // Peripherals kept alive in subsleep and watch
  localparam logic [9:0] PMC_SUBSLP_RUN = 10'h07f;
  localparam logic [9:0] PMC_WATCH_RUN = 10'h06d;

  // Wake-up source vector layout
  typedef struct packed {
    logic tma;
    logic tmc;
    logic tmf;
    logic tmg;
    logic ser;
    logic ext4;
    logic ext3;
    logic ext1;
    logic ext0;
    logic aec;
    logic [7:0] pins;
    logic other;
  } pmc_wake_t;

  // Control bits set by software
  typedef struct packed {
    logic low_speed_flag;
    logic medium_speed_flag;
    logic software_standby_bit;
    logic timer_a_clock_source_bit;
    logic direct_transfer_bit;
    logic [2:0] standby_wait_select;
    logic [1:0] medium_div_select;
  } pmc_ctrl_t;

  // Reset values and counts
  localparam logic [2:0] PMC_STS_RESET = 3'h0;
  localparam int PMC_MIN_WAIT = 8;
  localparam int PMC_CNT_W = 18;
  localparam int PMC_DIV_W = 7;

  // Exit wait lengths in states, one per select code
  localparam logic [17:0] PMC_WAIT_SEL0 = 18'h02000; // Default after reset
  localparam logic [17:0] PMC_WAIT_SEL1 = 18'h04000;
  localparam logic [17:0] PMC_WAIT_SEL2 = 18'h08000;
  localparam logic [17:0] PMC_WAIT_SEL3 = 18'h10000;
  localparam logic [17:0] PMC_WAIT_SEL4 = 18'h20000;
  localparam logic [17:0] PMC_WAIT_SEL5 = 18'h00002; // External clock only
  localparam logic [17:0] PMC_WAIT_SEL6 = 18'h00008;
  localparam logic [17:0] PMC_WAIT_SEL7 = 18'h00010;

endpackage

/* File: verilog/pmc_power_mode_controller.sv */
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // Software control
  input wire pmc_ctrl_t CTRL,
  input wire logic [PMC_NPER-1:0] MODULE_STANDBY,
  input wire logic SLEEP_EXEC,
  // Interrupt requests and their enables
  input wire pmc_wake_t IRQ_REQ,
  input wire pmc_wake_t IRQ_EN,
  // Mode and clock outputs
  output pmc_mode_t MODE,
  output logic POWER_DOWN,
  output logic CPU_RUN,
  output logic SYS_OSC_ON,
  output logic SUB_CLK_SEL,
  output logic [PMC_NPER-1:0] PER_CLK_EN,
  output logic WAKE
);

  // Wait counts in states, index by select code
  function automatic logic [PMC_CNT_W-1:0] wait_len(input logic [2:0] sel);
    case (sel)
      3'h0: wait_len = PMC_WAIT_SEL0;
      3'h1: wait_len = PMC_WAIT_SEL1;
      3'h2: wait_len = PMC_WAIT_SEL2;
      3'h3: wait_len = PMC_WAIT_SEL3;
      3'h4: wait_len = PMC_WAIT_SEL4;
      3'h5: wait_len = PMC_WAIT_SEL5;
      3'h6: wait_len = PMC_WAIT_SEL6;
      default: wait_len = PMC_WAIT_SEL7;
    endcase
  endfunction

  pmc_mode_t mode; // Current mode
  pmc_mode_t next_mode; // Mode after this cycle
  pmc_mode_t wait_target; // Active mode entered after the wait
  logic [PMC_CNT_W-1:0] wait_cnt; // Remaining wait states
  logic [PMC_CNT_W-1:0] wait_load; // Length of the chosen wait
  logic [PMC_DIV_W-1:0] div_cnt; // Free-running divider
  logic div_tick; // Medium-speed enable pulse
  logic wake_any; // Enabled wake in current mode
  logic wake_sel; // Enabled requests masked by source set
  pmc_wake_t live; // Pending and enabled

  // Only enabled requests count; pending alone never wakes
  assign live = IRQ_REQ & IRQ_EN; // see RULE12

  // Source set per low-power mode
  always_comb begin
    wake_sel = 1'b0;
    case (mode)
      PMC_WATCH: begin
        wake_sel = live.tma | live.tmf | live.tmg | live.ext0 | (|live.pins); // see RULE13
      end
      PMC_SUBSLP: begin
        wake_sel = live.tma | live.tmc | live.tmf | live.tmg | live.ser | live.ext4
          | live.ext3 | live.ext1 | live.ext0 | live.aec | (|live.pins); // see RULE14
      end
      PMC_STANDBY: begin
        wake_sel = live.ext1 | live.ext0 | (|live.pins); // see RULE15
      end
      PMC_SLP_HI, PMC_SLP_MED: begin
        wake_sel = |live; // see RULE15
      end
      default: begin
        wake_sel = 1'b0;
      end
    endcase
  end
  assign wake_any = wake_sel;

  // Medium-speed divider, ratio 16/32/64/128
  always_comb begin
    case (CTRL.medium_div_select)
      2'h0: div_tick = (div_cnt[6:0] == 7'h00); // 1/128
      2'h1: div_tick = (div_cnt[5:0] == 6'h00); // 1/64
      2'h2: div_tick = (div_cnt[4:0] == 5'h00); // 1/32
      default: div_tick = (div_cnt[3:0] == 4'h0); // 1/16
    endcase
  end

  // Wait length never below eight states unless external clock
  always_comb begin
    wait_load = wait_len(CTRL.standby_wait_select); // see RULE19
    if (CTRL.standby_wait_select != 3'h5 && wait_load < PMC_CNT_W'(PMC_MIN_WAIT)) begin
      wait_load = PMC_CNT_W'(PMC_MIN_WAIT); // see RULE20
    end
  end

  // Next mode decision
  always_comb begin
    next_mode = mode;
    case (mode)
      PMC_ACT_HI, PMC_ACT_MED: begin
        if (SLEEP_EXEC) begin
          // Five control bits pick the target
          if (!CTRL.software_standby_bit) begin // see RULE16
            if (CTRL.direct_transfer_bit) begin
              if (CTRL.low_speed_flag && CTRL.timer_a_clock_source_bit) begin
                next_mode = PMC_SUBACT;
              end else begin
                next_mode = CTRL.medium_speed_flag ? PMC_ACT_MED : PMC_ACT_HI;
              end
            end else if (CTRL.low_speed_flag && CTRL.timer_a_clock_source_bit) begin
              next_mode = PMC_SUBSLP;
            end else begin
              next_mode = CTRL.medium_speed_flag ? PMC_SLP_MED : PMC_SLP_HI; // see RULE18
            end
          end else if (CTRL.timer_a_clock_source_bit) begin
            next_mode = (CTRL.direct_transfer_bit && CTRL.low_speed_flag) ? PMC_SUBACT
              : PMC_WATCH; // see RULE18
          end else begin
            next_mode = PMC_STANDBY; // see RULE18
          end
        end
      end
      PMC_SUBACT: begin
        if (SLEEP_EXEC) begin
          if (CTRL.direct_transfer_bit && !CTRL.low_speed_flag) begin
            next_mode = PMC_WAIT; // Return to active via oscillator wait
          end else if (CTRL.software_standby_bit) begin
            next_mode = PMC_WATCH;
          end else begin
            next_mode = PMC_SUBSLP;
          end
        end
      end
      PMC_SLP_HI, PMC_SLP_MED: begin
        if (wake_any) begin
          next_mode = CTRL.medium_speed_flag ? PMC_ACT_MED : PMC_ACT_HI;
        end
      end
      PMC_SUBSLP, PMC_WATCH: begin
        if (wake_any) begin
          next_mode = CTRL.low_speed_flag ? PMC_SUBACT : PMC_WAIT;
        end
      end
      PMC_STANDBY: begin
        if (wake_any) begin
          next_mode = PMC_WAIT;
        end
      end
      PMC_WAIT: begin
        if (wait_cnt == '0) begin
          next_mode = wait_target;
        end
      end
      default: begin
        next_mode = PMC_ACT_HI;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      mode <= PMC_ACT_HI; // see RULE1
    end else begin
      mode <= next_mode;
    end
  end

  // Wait counter, loaded on entry to the wait
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      wait_cnt <= '0;
      wait_target <= PMC_ACT_HI;
    end else if (next_mode == PMC_WAIT && mode != PMC_WAIT) begin
      wait_cnt <= wait_load - 18'h00001; // see RULE19
      wait_target <= CTRL.medium_speed_flag ? PMC_ACT_MED : PMC_ACT_HI;
    end else if (mode == PMC_WAIT && wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 18'h00001; // see RULE20
    end
  end

  // Free-running divider; phase not reset on mode entry, so first pulse may come early
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      MODE <= PMC_ACT_HI;
      POWER_DOWN <= 1'b0;
      CPU_RUN <= 1'b1;
      SYS_OSC_ON <= 1'b1;
      SUB_CLK_SEL <= 1'b0;
      PER_CLK_EN <= '1;
      WAKE <= 1'b0;
    end else begin
      MODE <= next_mode;
      POWER_DOWN <= (next_mode != PMC_ACT_HI); // see RULE2
      CPU_RUN <= next_mode inside {PMC_ACT_HI, PMC_ACT_MED, PMC_SUBACT}; // see RULE6
      SYS_OSC_ON <= !(next_mode inside {PMC_WATCH, PMC_SUBACT, PMC_SUBSLP,
        PMC_STANDBY}); // see RULE17
      SUB_CLK_SEL <= next_mode inside {PMC_SUBACT, PMC_SUBSLP, PMC_WATCH}; // see RULE5
      WAKE <= wake_any && next_mode != mode;
      // Per-peripheral enables, module standby overrides all
      case (next_mode)
        PMC_ACT_HI, PMC_SLP_HI, PMC_SUBACT: begin
          PER_CLK_EN <= ~MODULE_STANDBY; // see RULE3 see RULE11
        end
        PMC_ACT_MED, PMC_SLP_MED: begin
          PER_CLK_EN <= div_tick ? ~MODULE_STANDBY : '0; // see RULE4 see RULE7
        end
        PMC_SUBSLP: begin
          PER_CLK_EN <= PMC_SUBSLP_RUN & ~MODULE_STANDBY; // see RULE8
        end
        PMC_WATCH: begin
          PER_CLK_EN <= PMC_WATCH_RUN & ~MODULE_STANDBY; // see RULE9
        end
        default: begin
          PER_CLK_EN <= '0; // see RULE10
        end
      endcase
    end
  end

endmodule

/* File: dv/pmc_wake_model.sv */
module pmc_wake_model
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands
  input wire pmc_wake_t fire,
  input wire logic clr,
  // Controller side
  input wire logic wake,
  output pmc_wake_t req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Request stays pending until served, so a refused one lingers
  always_ff @(posedge clk) begin
    if (rst || clr || wake) begin
      req <= '0;
    end else begin
      req <= req | fire;
    end
  end
endmodule

/* File: dv/pmc_power_mode_controller_properties.sv */
module pmc_power_mode_controller_properties
  import pmc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // Controls and wake inputs
  input wire pmc_ctrl_t CTRL,
  input wire logic SLEEP_EXEC,
  input wire pmc_wake_t IRQ_REQ,
  input wire pmc_wake_t IRQ_EN,
  // Observed outputs
  input wire pmc_mode_t MODE,
  input wire logic POWER_DOWN,
  input wire logic CPU_RUN,
  input wire logic SYS_OSC_ON,
  input wire logic [PMC_NPER-1:0] PER_CLK_EN,
  input wire logic WAKE
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so clock and reset are given once
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  property p_pd; POWER_DOWN == (MODE != PMC_ACT_HI); endproperty
  a_pd: assert property (p_pd) else $error("power-down flag wrong");
  property p_cpu; CPU_RUN == (MODE inside {PMC_ACT_HI, PMC_ACT_MED, PMC_SUBACT}); endproperty
  a_cpu: assert property (p_cpu) else $error("cpu run wrong");
  property p_osc; SYS_OSC_ON == !(MODE inside {PMC_WATCH, PMC_SUBACT, PMC_SUBSLP, PMC_STANDBY});
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator wrong");
  property p_stby; MODE inside {PMC_STANDBY, PMC_WAIT} |-> PER_CLK_EN == '0; endproperty
  a_stby: assert property (p_stby) else $error("clocks in standby");
  property p_watch; MODE == PMC_WATCH |-> (PER_CLK_EN & ~PMC_WATCH_RUN) == '0; endproperty
  a_watch: assert property (p_watch) else $error("extra clocks in watch");
  // Wake only from an enabled request and only with a mode change
  property p_wake; WAKE |-> MODE != $past(MODE) && |($past(IRQ_REQ) & $past(IRQ_EN)); endproperty
  a_wake: assert property (p_wake) else $error("wake without cause");
  property p_slp; SLEEP_EXEC && MODE == PMC_ACT_HI && CTRL[9:5] == 5'h0 |=> MODE == PMC_SLP_HI;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep target wrong");
  // Code 5 is the short external-clock wait, excluded
  property p_wait; $rose(MODE == PMC_WAIT) && CTRL.standby_wait_select != 3'h5
    |-> (MODE == PMC_WAIT) [*7]; endproperty
  a_wait: assert property (p_wait) else $error("restart wait too short");
endmodule

bind pmc_power_mode_controller pmc_power_mode_controller_properties u_props (.CLK_SYS, .SRST,
  .CTRL, .SLEEP_EXEC, .IRQ_REQ, .IRQ_EN, .MODE, .POWER_DOWN, .CPU_RUN, .SYS_OSC_ON,
  .PER_CLK_EN, .WAKE);

/* File: dv/testbench.sv */
module testbench
  import pmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus and observed values
  logic clk = 0, srst = 1, slp = 0, clr = 0, pd, cpu, osc, sub, wake;
  pmc_ctrl_t ctrl = '0;
  pmc_wake_t en = '0, fire = '0, req;
  logic [9:0] ms = '0, pce;
  logic [1:0] d;
  pmc_mode_t mode;
  int error_cnt = 0, checks = 0, n;

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  pmc_power_mode_controller DUT (.CLK_SYS(clk), .SRST(srst), .CTRL(ctrl), .MODULE_STANDBY(ms),
    .SLEEP_EXEC(slp), .IRQ_REQ(req), .IRQ_EN(en), .MODE(mode), .POWER_DOWN(pd), .CPU_RUN(cpu),
    .SYS_OSC_ON(osc), .SUB_CLK_SEL(sub), .PER_CLK_EN(pce), .WAKE(wake));
  // Wake sources hold requests like real peripherals
  pmc_wake_model u_src (.clk(clk), .rst(srst), .fire(fire), .clr(clr), .wake(wake), .req(req));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Step past edges so their updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Enable pulses of peripheral 0 over 512 cycles, left in n
  task automatic pulses();
    n = 0;
    repeat (512) begin
      tick(1);
      n += pce[0];
    end
  endtask
  task automatic sleep();
    @(posedge clk) slp <= 1'b1;
    @(posedge clk) slp <= 1'b0;
    #1;
  endtask
  task automatic raise(input pmc_wake_t v);
    @(posedge clk) fire <= v;
    @(posedge clk) fire <= '0;
    #1;
  endtask
  // Bounded wait for a mode; n counts cycles spent
  task automatic waitm(input pmc_mode_t m);
    n = 0;
    while (mode !== m && n < 400) begin
      tick(1);
      n++;
    end
    if (mode !== m) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic test_done();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Exit wait per select code
  function automatic int wlen(input logic [2:0] s);
    int t[8] = '{8192, 16384, 32768, 65536, 131072, 2, 8, 16};
    return t[s];
  endfunction

  initial begin
    void'($urandom(32'hdeb0));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    tick(1);
    chk({mode, pd, cpu, osc, sub, wake, pce}, {PMC_ACT_HI, 5'b01100, 10'h3ff});
    @(posedge clk) ms <= 10'($urandom);
    tick(2);
    chk(pce, 10'(~ms));
    @(posedge clk) ms <= '0;
    sleep();
    chk({mode, cpu}, {PMC_SLP_HI, 1'b0});
    raise(19'h1);
    tick(3);
    chk(mode, PMC_SLP_HI);
    @(posedge clk) en <= '1;
    #1;
    waitm(PMC_ACT_HI);
    chk(wake, 1'b1);
    // Standby, watch, then standby with the short external-clock wait; outside source first
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) ctrl <= {3'b001, k[0], 1'b0, k[1] ? 3'h5 : 3'(6 + k), 2'h0};
      sleep();
      chk({mode, osc, pce}, k[0] ? {PMC_WATCH, 11'h06d} : {PMC_STANDBY, 11'h0});
      raise(k[0] ? 19'h20000 : 19'h40000);
      tick(3);
      chk(mode, k[0] ? PMC_WATCH : PMC_STANDBY);
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      raise(19'h400);
      waitm(PMC_WAIT);
      waitm(PMC_ACT_HI);
      chk(n, wlen(ctrl.standby_wait_select));
    end
    @(posedge clk) ctrl <= 10'h278;
    sleep();
    chk({mode, cpu, sub, osc}, {PMC_SUBACT, 3'b110});
    @(posedge clk) ctrl <= 10'h258;
    sleep();
    chk({mode, pce}, {PMC_SUBSLP, 10'h07f});
    raise(19'h4000);
    waitm(PMC_SUBACT);
    @(posedge clk) ctrl <= 10'h078;
    sleep();
    waitm(PMC_ACT_HI);
    // Random divider in medium sleep and medium active; count enable pulses
    for (int k = 0; k < 3; k++) begin
      d = 2'($urandom);
      @(posedge clk) ctrl <= 10'h118 | 10'(d);
      sleep();
      chk(mode, PMC_SLP_MED);
      pulses();
      chk(n, 4 << d);
      raise(19'h1);
      waitm(PMC_ACT_MED);
      chk(pd, 1'b1);
      pulses();
      chk(n, 4 << d);
    end
    test_done();
  end
endmodule
